// ===== inc/bmszvl_pkg.sv
// constants, enumerations and input bit positions of the buck mode
// select, zero-cross and valley limit control block.
// assumes a single 25 MHz control clock in the device.
package bmszvl_pkg;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_MHZ = 25; // control clock rate
   localparam int UV_WAIT_US = 70; // undervoltage wait in microseconds
   localparam int UV_WAIT_CYC = UV_WAIT_US * CLK_MHZ; // wait in clocks
   localparam int HICCUP_SS_MULT = 7; // sleep, in soft-start periods
   localparam int ZC_REENTRY_RUN = 16; // clean cycles to re-enter dcm
   localparam int SS_ZC_CYCLES = 32; // zc window at soft start

   // ***************************************************
   // strap decode
   // ***************************************************
   localparam logic [4:0] STRAP_LAST = 5'h17; // highest code (float)
   localparam logic [4:0] STRAP_HALF = 5'h0c; // first skip-mode code
   localparam logic [2:0] RAMP_TOP = 3'h4; // ramp of a group's first code
   localparam logic [1:0] FREQ_800K = 2'h0; // 800 khz
   localparam logic [1:0] FREQ_1100K = 2'h1; // 1100 khz
   localparam logic [1:0] FREQ_1400K = 2'h2; // 1400 khz

   // ***************************************************
   // positions inside the synchronised input vector
   // ***************************************************
   localparam int IN_W = 16; // vector width
   localparam int IX_EN = 0; // output enable
   localparam int IX_CYC = 1; // switching cycle end strobe
   localparam int IX_ZC = 2; // current below zero-cross threshold
   localparam int IX_OVL = 3; // current above valley limit
   localparam int IX_LS = 4; // low-side switch conducting
   localparam int IX_HS = 5; // high-side on-time active
   localparam int IX_SSD = 6; // soft start done
   localparam int IX_UV = 7; // feedback below 79 percent
   localparam int IX_PG = 8; // feedback above 91 percent
   localparam int IX_RLO = 9; // limit resistor too small or shorted
   localparam int IX_RSV = 10; // spare, tied low
   localparam int IX_STRAP = 11; // lsb of the 5-bit strap code

   // ***************************************************
   // state enumerations
   // ***************************************************
   typedef enum logic {BMSZVL_CCM, BMSZVL_DCM} bmszvl_cond_e;
   typedef enum logic [2:0]
   {
      BMSZVL_OFF,
      BMSZVL_RUN,
      BMSZVL_UV_WAIT,
      BMSZVL_HICCUP,
      BMSZVL_LATCHED
   } bmszvl_prot_e;

endpackage

// ===== hdl/bmszvl_top.sv
// digital control of the synchronous buck: strap latch, zero-cross and
// discontinuous conduction sequencing, valley limit and undervoltage.
// assumes analog comparators and timers drive the inputs asynchronously
// and the power stage acts on the registered outputs.
`timescale 1ns/1ps

module bmszvl_top
#(
   parameter int POR_DELAY_CYC = 1024, // power-on delay in clocks
   parameter int SS_PERIOD_CYC = 25000, // one soft-start period in clocks
   parameter bit HICCUP_VARIANT = 1'b1, // 1 hiccup, 0 latch off
   parameter int TW = 20 // timer width
)
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic [4:0] strap_code_i,
   input wire logic cycle_end_i,
   input wire logic zc_below_i,
   input wire logic over_limit_i,
   input wire logic lowside_on_i,
   input wire logic highside_on_i,
   input wire logic ss_done_i,
   input wire logic fb_below_uv_i,
   input wire logic fb_above_pg_i,
   input wire logic limit_res_low_i,
   output logic config_valid_o,
   output logic forced_continuous_mode_o,
   output logic [1:0] freq_sel_o,
   output logic [2:0] ramp_setting_o,
   output logic converter_run_o,
   output logic zero_cross_detect_en_o,
   output logic discontinuous_conduction_o,
   output logic zc_threshold_pos_o,
   output logic lowside_zc_off_o,
   output logic valley_current_limit_o,
   output logic limit_clamp_o,
   output logic undervoltage_event_o,
   output logic hiccup_active_o,
   output logic latched_off_o
);

   // ***************************************************
   // constants and state
   // ***************************************************
   localparam int HICCUP_CYC = bmszvl_pkg::HICCUP_SS_MULT * SS_PERIOD_CYC;
   localparam logic [TW-1:0] UV_END = TW'(bmszvl_pkg::UV_WAIT_CYC - 1);
   localparam logic [TW-1:0] HIC_END = TW'(HICCUP_CYC - 1);
   localparam logic [15:0] POR_END = 16'(POR_DELAY_CYC - 1);
   localparam logic [4:0] RUN_END = 5'(bmszvl_pkg::ZC_REENTRY_RUN - 1);
   localparam logic [5:0] SS_FULL = 6'(bmszvl_pkg::SS_ZC_CYCLES);

   typedef struct packed
   {
      logic [bmszvl_pkg::IN_W-1:0] s1; // synchroniser first stage
      logic [bmszvl_pkg::IN_W-1:0] s2; // synchroniser second stage
      logic cyc_prev; // last cycle strobe level
      logic hs_prev; // last high-side level
      logic [15:0] por_cnt; // power-on delay count
      logic cfg_valid; // strap frozen
      logic forced_continuous_mode; // forced continuous selected
      logic [1:0] freq; // frequency code
      logic [2:0] ramp; // ramp setting 1..4
      bmszvl_pkg::bmszvl_prot_e prot; // protection state
      logic [TW-1:0] tmr; // uv wait and hiccup timer
      logic [5:0] ss_cnt; // cycles since running began, cleared outside run, saturating
      logic hs_after; // high-side pulse ended after soft start
      logic zc_en; // zero-cross detection active
      bmszvl_pkg::bmszvl_cond_e cond; // conduction mode
      logic [4:0] run; // consecutive zero-cross cycles
      logic ls_off; // low side off at zero-cross
      logic hold; // valley limit holding low side
      logic clamp; // internal clamp in force
   } bmszvl_state_s;

   bmszvl_state_s q_r; // registered state
   bmszvl_state_s q_nxt; // next state

   // ***************************************************
   // strap decode
   // ***************************************************
   // returns {forced_continuous_mode, freq[1:0], ramp[2:0]}; codes above the last one
   // read as the floating pin so a bad detector still gives a legal mode
   function automatic logic [5:0] strap_decode(input logic [4:0] code);
      logic [4:0] c;
      logic [4:0] w;
      logic fc;
      c = (code > bmszvl_pkg::STRAP_LAST) ? bmszvl_pkg::STRAP_LAST : code;
      fc = (c < bmszvl_pkg::STRAP_HALF);
      w = fc ? c : 5'(c - bmszvl_pkg::STRAP_HALF);
      // groups of four step the frequency, ramp counts down in a group
      strap_decode = {fc, w[3:2],
         3'(bmszvl_pkg::RAMP_TOP - {1'b0, w[1:0]})};
   endfunction

   // ***************************************************
   // next-state logic
   // ***************************************************
   always_comb
   begin
      logic en;
      logic cyc_evt;
      logic hs_fall;
      logic ssd;
      logic running;
      logic zc;
      en = 1'b0;
      cyc_evt = 1'b0;
      hs_fall = 1'b0;
      ssd = 1'b0;
      running = 1'b0;
      zc = 1'b0;
      q_nxt = q_r;
      // inputs come from analog blocks, so two stages before any use
      q_nxt.s1 = {strap_code_i, 1'b0, limit_res_low_i, fb_above_pg_i,
         fb_below_uv_i, ss_done_i, highside_on_i, lowside_on_i,
         over_limit_i, zc_below_i, cycle_end_i, enable_i};
      q_nxt.s2 = q_r.s1;
      en = q_r.s2[bmszvl_pkg::IX_EN];
      ssd = q_r.s2[bmszvl_pkg::IX_SSD];
      zc = q_r.s2[bmszvl_pkg::IX_ZC];
      q_nxt.cyc_prev = q_r.s2[bmszvl_pkg::IX_CYC];
      q_nxt.hs_prev = q_r.s2[bmszvl_pkg::IX_HS];
      cyc_evt = q_r.s2[bmszvl_pkg::IX_CYC] & ~q_r.cyc_prev;
      hs_fall = ~q_r.s2[bmszvl_pkg::IX_HS] & q_r.hs_prev;

      // strap follows the pin only until the delay ends
      if (!q_r.cfg_valid)
      begin
         {q_nxt.forced_continuous_mode, q_nxt.freq, q_nxt.ramp} = strap_decode(
            q_r.s2[bmszvl_pkg::IX_STRAP +: 5]);
         q_nxt.por_cnt = 16'(q_r.por_cnt + 16'h0001);
         if (q_r.por_cnt == POR_END)
         begin
            q_nxt.cfg_valid = 1'b1;
         end
      end

      // protection sequence
      case (q_r.prot)
         bmszvl_pkg::BMSZVL_OFF:
         begin
            q_nxt.tmr = '0;
            if (en && q_r.cfg_valid)
            begin
               q_nxt.prot = bmszvl_pkg::BMSZVL_RUN;
            end
         end
         bmszvl_pkg::BMSZVL_RUN:
         begin
            // comparator ignored until soft start ends
            if (ssd && q_r.s2[bmszvl_pkg::IX_UV])
            begin
               q_nxt.prot = bmszvl_pkg::BMSZVL_UV_WAIT;
               q_nxt.tmr = '0;
            end
         end
         bmszvl_pkg::BMSZVL_UV_WAIT:
         begin
            if (q_r.s2[bmszvl_pkg::IX_PG])
            begin
               q_nxt.prot = bmszvl_pkg::BMSZVL_RUN;
               q_nxt.tmr = '0;
            end
            else if (q_r.tmr == UV_END)
            begin
               q_nxt.tmr = '0;
               q_nxt.prot = HICCUP_VARIANT ? bmszvl_pkg::BMSZVL_HICCUP
                  : bmszvl_pkg::BMSZVL_LATCHED;
            end
            else
            begin
               q_nxt.tmr = TW'(q_r.tmr + 1'b1);
            end
         end
         bmszvl_pkg::BMSZVL_HICCUP:
         begin
            // switching stops so the soft start restarts afterwards
            if (q_r.tmr == HIC_END)
            begin
               q_nxt.tmr = '0;
               q_nxt.prot = bmszvl_pkg::BMSZVL_RUN;
            end
            else
            begin
               q_nxt.tmr = TW'(q_r.tmr + 1'b1);
            end
         end
         bmszvl_pkg::BMSZVL_LATCHED:
         begin
            q_nxt.tmr = '0; // only enable low releases it
         end
         default:
         begin
            q_nxt.prot = bmszvl_pkg::BMSZVL_OFF;
            q_nxt.tmr = '0;
         end
      endcase
      if (!en)
      begin
         q_nxt.prot = bmszvl_pkg::BMSZVL_OFF;
         q_nxt.tmr = '0;
      end
      running = (q_nxt.prot == bmszvl_pkg::BMSZVL_RUN) ||
         (q_nxt.prot == bmszvl_pkg::BMSZVL_UV_WAIT);

      // soft-start zero-cross window
      if (!running)
      begin
         q_nxt.ss_cnt = '0;
         q_nxt.hs_after = 1'b0;
      end
      else
      begin
         if (cyc_evt && q_r.ss_cnt != SS_FULL)
         begin
            q_nxt.ss_cnt = 6'(q_r.ss_cnt + 6'h01);
         end
         if (ssd && hs_fall)
         begin
            q_nxt.hs_after = 1'b1;
         end
      end
      // skip mode keeps detection; forced continuous drops it once soft
      // start is done and either 32 cycles or one on-time have passed
      q_nxt.zc_en = running && (!q_r.forced_continuous_mode || !ssd ||
         !((q_r.ss_cnt == SS_FULL) || q_r.hs_after));

      // conduction mode
      if (!q_r.zc_en)
      begin
         q_nxt.cond = bmszvl_pkg::BMSZVL_CCM;
         q_nxt.run = '0;
      end
      else if (cyc_evt)
      begin
         case (q_r.cond)
            bmszvl_pkg::BMSZVL_CCM:
            begin
               if (!zc)
               begin
                  q_nxt.run = '0; // a break restarts the run
               end
               else if (q_r.run == RUN_END)
               begin
                  q_nxt.run = '0;
                  q_nxt.cond = bmszvl_pkg::BMSZVL_DCM;
               end
               else
               begin
                  q_nxt.run = 5'(q_r.run + 5'h01);
               end
            end
            bmszvl_pkg::BMSZVL_DCM:
            begin
               if (!zc)
               begin
                  q_nxt.cond = bmszvl_pkg::BMSZVL_CCM;
                  q_nxt.run = '0;
               end
            end
            default:
            begin
               q_nxt.cond = bmszvl_pkg::BMSZVL_CCM;
               q_nxt.run = '0;
            end
         endcase
      end

      // switch commands, delayed by the synchroniser
      q_nxt.ls_off = q_r.zc_en && zc &&
         q_r.s2[bmszvl_pkg::IX_LS];
      q_nxt.hold = running && q_r.s2[bmszvl_pkg::IX_LS] &&
         q_r.s2[bmszvl_pkg::IX_OVL];
      q_nxt.clamp = q_r.s2[bmszvl_pkg::IX_RLO];
   end

   // ***************************************************
   // state register
   // ***************************************************
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         q_r <= '0;
         q_r.prot <= bmszvl_pkg::BMSZVL_OFF;
         q_r.cond <= bmszvl_pkg::BMSZVL_CCM;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   // ***************************************************
   // outputs, all from the state register
   // ***************************************************
   assign config_valid_o = q_r.cfg_valid;
   assign forced_continuous_mode_o = q_r.forced_continuous_mode;
   assign freq_sel_o = q_r.freq;
   assign ramp_setting_o = q_r.ramp;
   assign converter_run_o = (q_r.prot == bmszvl_pkg::BMSZVL_RUN) ||
      (q_r.prot == bmszvl_pkg::BMSZVL_UV_WAIT);
   assign zero_cross_detect_en_o = q_r.zc_en;
   assign discontinuous_conduction_o = (q_r.cond == bmszvl_pkg::BMSZVL_DCM);
   // low means the small negative threshold, high the positive one
   assign zc_threshold_pos_o =
      (q_r.cond == bmszvl_pkg::BMSZVL_DCM);
   assign lowside_zc_off_o = q_r.ls_off;
   assign valley_current_limit_o = q_r.hold;
   assign limit_clamp_o = q_r.clamp;
   assign undervoltage_event_o = (q_r.prot == bmszvl_pkg::BMSZVL_UV_WAIT);
   assign hiccup_active_o = (q_r.prot == bmszvl_pkg::BMSZVL_HICCUP);
   assign latched_off_o = (q_r.prot == bmszvl_pkg::BMSZVL_LATCHED);

endmodule

// ===== tb/bmszvl_asserts.sv
// checker for the mode select, zero-cross and valley limit block.
// assumes it is bound into bmszvl_top and sees its ports only.
`timescale 1ns/1ps

module bmszvl_asserts
#(
   parameter int SS_PERIOD_CYC = 25000 // soft-start period in clocks
)
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic zc_below_i,
   input wire logic over_limit_i,
   input wire logic lowside_on_i,
   input wire logic ss_done_i,
   input wire logic fb_below_uv_i,
   input wire logic limit_res_low_i,
   input wire logic config_valid_o,
   input wire logic [1:0] freq_sel_o,
   input wire logic [2:0] ramp_setting_o,
   input wire logic converter_run_o,
   input wire logic discontinuous_conduction_o,
   input wire logic zc_threshold_pos_o,
   input wire logic lowside_zc_off_o,
   input wire logic valley_current_limit_o,
   input wire logic limit_clamp_o,
   input wire logic undervoltage_event_o,
   input wire logic hiccup_active_o
);
   // ********
   // helpers
   // ********
   int uv_n_r; // clocks spent in the undervoltage wait
   int hic_n_r; // clocks spent asleep in hiccup
   // run lengths, cleared as soon as the state is left
   always_ff @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         uv_n_r <= 0;
         hic_n_r <= 0;
      end
      else
      begin
         uv_n_r <= undervoltage_event_o ? uv_n_r + 1 : 0;
         hic_n_r <= hiccup_active_o ? hic_n_r + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // ********
   // properties, pin to output is three edges
   // ********
   property p_clamp;
      limit_clamp_o == $past(limit_res_low_i, 3);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("clamp does not follow resistor flag");
   property p_cfg_hold;
      config_valid_o |=> config_valid_o && $stable(freq_sel_o)
         && $stable(ramp_setting_o);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("latched configuration changed");
   property p_thr;
      zc_threshold_pos_o == discontinuous_conduction_o &&
         (!$rose(zc_threshold_pos_o) || lowside_zc_off_o);
   endproperty
   a_thr: assert property (p_thr)
      else $error("threshold sign wrong or raised without zero cross");
   property p_valley;
      valley_current_limit_o |-> $past(over_limit_i, 3)
         && $past(lowside_on_i, 3);
   endproperty
   a_valley: assert property (p_valley)
      else $error("valley limit without cause");
   property p_lszc;
      lowside_zc_off_o |-> $past(zc_below_i, 3) && $past(lowside_on_i, 3);
   endproperty
   a_lszc: assert property (p_lszc)
      else $error("low side released without zero cross");
   property p_uv_rise;
      $rose(undervoltage_event_o) |-> $past(fb_below_uv_i, 3)
         && $past(ss_done_i, 3);
   endproperty
   a_uv_rise: assert property (p_uv_rise)
      else $error("undervoltage wait without armed fault");
   property p_uv_len;
      $rose(hiccup_active_o) |-> uv_n_r == 1750;
   endproperty
   a_uv_len: assert property (p_uv_len)
      else $error("undervoltage wait length wrong");
   property p_hic_len;
      $fell(hiccup_active_o) |-> converter_run_o
         && hic_n_r == bmszvl_pkg::HICCUP_SS_MULT * SS_PERIOD_CYC;
   endproperty
   a_hic_len: assert property (p_hic_len)
      else $error("hiccup sleep length wrong");
endmodule

bind bmszvl_top bmszvl_asserts #(.SS_PERIOD_CYC(SS_PERIOD_CYC)) u_chk
(
   .mclk_i, .reset_i, .zc_below_i, .over_limit_i, .lowside_on_i,
   .ss_done_i, .fb_below_uv_i, .limit_res_low_i, .config_valid_o,
   .freq_sel_o, .ramp_setting_o, .converter_run_o,
   .discontinuous_conduction_o, .zc_threshold_pos_o, .lowside_zc_off_o,
   .valley_current_limit_o, .limit_clamp_o, .undervoltage_event_o,
   .hiccup_active_o
);

// ===== tb/bmszvl_stage_model.sv
// power stage and comparator stand-in: one switching cycle per 8 clocks.
// assumes run_i comes from the block and the bench steers zc_i.
`timescale 1ns/1ps

module bmszvl_stage_model
(
   input wire logic mclk_i,
   input wire logic run_i,
   input wire logic zc_i,
   output logic cycle_end_o,
   output logic highside_on_o,
   output logic lowside_on_o,
   output logic zc_below_o
);
   logic [2:0] ph_r = 3'h0; // phase in the cycle, cleared to zero while stopped
   logic zc_r = 1'b0; // comparator result held for the whole cycle
   // one result per cycle, taken in the last clock of the high-side on-time
   always @(posedge mclk_i)
   begin
      ph_r <= run_i ? ph_r + 3'h1 : 3'h0;
      if (ph_r == 3'h2)
         zc_r <= zc_i;
   end
   assign highside_on_o = run_i && ph_r < 3'h3;
   assign lowside_on_o = run_i && ph_r >= 3'h3;
   assign zc_below_o = zc_r && lowside_on_o;
   // end strobe high two clocks, low six
   assign cycle_end_o = run_i && ph_r >= 3'h6;
endmodule

// ===== tb/tb.sv
// bench for bmszvl_top: strap decode, zero-cross sequencing, limits.
// assumes the stage model paces switching cycles.
`timescale 1ns/1ps

module tb;
   localparam int POR = 8; // shortened power-on delay
   localparam int SSP = 10; // shortened soft-start period
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1, enable_i = 1'b0, ss_done_i = 1'b0;
   logic fb_below_uv_i = 1'b0, fb_above_pg_i = 1'b0, over_limit_i = 1'b0;
   logic limit_res_low_i = 1'b0, zc_sel = 1'b0;
   logic [4:0] strap_code_i = 5'h00;
   logic cycle_end_i, zc_below_i, lowside_on_i, highside_on_i;
   logic config_valid_o, forced_continuous_mode_o, converter_run_o;
   logic zero_cross_detect_en_o, discontinuous_conduction_o;
   logic zc_threshold_pos_o, lowside_zc_off_o, valley_current_limit_o;
   logic limit_clamp_o, undervoltage_event_o, hiccup_active_o;
   logic latched_off_o;
   logic [1:0] freq_sel_o;
   logic [2:0] ramp_setting_o;
   int n_mismatch = 0, checks_done = 0, ticks = 0;
   bmszvl_top #(.POR_DELAY_CYC(POR), .SS_PERIOD_CYC(SSP)) DUT
   (
      .mclk_i, .reset_i, .enable_i, .strap_code_i, .cycle_end_i,
      .zc_below_i, .over_limit_i, .lowside_on_i, .highside_on_i,
      .ss_done_i, .fb_below_uv_i, .fb_above_pg_i, .limit_res_low_i,
      .config_valid_o, .forced_continuous_mode_o, .freq_sel_o,
      .ramp_setting_o, .converter_run_o, .zero_cross_detect_en_o,
      .discontinuous_conduction_o, .zc_threshold_pos_o, .lowside_zc_off_o,
      .valley_current_limit_o, .limit_clamp_o, .undervoltage_event_o,
      .hiccup_active_o, .latched_off_o
   );
   bmszvl_stage_model u_stage
   (
      .mclk_i, .run_i(converter_run_o), .zc_i(zc_sel),
      .cycle_end_o(cycle_end_i), .highside_on_o(highside_on_i),
      .lowside_on_o(lowside_on_i), .zc_below_o(zc_below_i)
   );
   // ********
   // clock and hang guard
   // ********
   initial
      forever #20 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      ticks++;
      if (ticks == 20000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   // ********
   // tasks; inputs move 1 ns after the edge
   // ********
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge cycle_end_i);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // reset for three clocks, then wait out the power-on delay
   task automatic restart(input logic [4:0] code);
      reset_i = 1'b1;
      enable_i = 1'b0;
      ss_done_i = 1'b0;
      strap_code_i = code;
      step(3);
      reset_i = 1'b0;
      step(POR + 4);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ********
   // main sequence
   // ********
   initial
   begin
      int w;
      for (int c = 0; c < 24; c++)
      begin
         restart(5'(c));
         w = c % 12;
         chk("valid", config_valid_o, 8'h01);
         chk("forced_continuous_mode", forced_continuous_mode_o, 8'(c < 12));
         chk("freq", freq_sel_o, 8'(w / 4));
         chk("ramp", ramp_setting_o, 8'(4 - w % 4));
      end
      strap_code_i = 5'h00; // late change must be ignored
      step(6);
      chk("late forced_continuous_mode", forced_continuous_mode_o, 8'h00);
      chk("late ramp", ramp_setting_o, 8'h01);
      // skip mode: entry, exit and broken runs
      restart(5'h0c);
      zc_sel = 1'b1;
      enable_i = 1'b1;
      step(7);
      chk("zc on", zero_cross_detect_en_o, 8'h01);
      cyc(15);
      step(4);
      chk("dcm 15", discontinuous_conduction_o, 8'h00);
      cyc(1);
      step(4);
      chk("dcm 16", discontinuous_conduction_o, 8'h01);
      chk("thr pos", zc_threshold_pos_o, 8'h01);
      chk("ls off", lowside_zc_off_o, 8'h01);
      zc_sel = 1'b0;
      cyc(1);
      step(4);
      chk("dcm exit", discontinuous_conduction_o, 8'h00);
      chk("thr neg", zc_threshold_pos_o, 8'h00);
      zc_sel = 1'b1;
      cyc(10);
      zc_sel = 1'b0;
      cyc(1);
      zc_sel = 1'b1;
      cyc(15);
      step(4);
      chk("run broken", discontinuous_conduction_o, 8'h00);
      cyc(1);
      step(4);
      chk("run whole", discontinuous_conduction_o, 8'h01);
      over_limit_i = 1'b1;
      cyc(1);
      step(2);
      chk("valley", valley_current_limit_o, 8'h01);
      over_limit_i = 1'b0;
      limit_res_low_i = 1'b1;
      step(3);
      chk("clamp", limit_clamp_o, 8'h01);
      limit_res_low_i = 1'b0;
      // forced continuous with early soft-start end and undervoltage
      restart(5'h00);
      zc_sel = 1'b0;
      fb_below_uv_i = 1'b1;
      enable_i = 1'b1;
      cyc(4);
      step(1);
      chk("ss zc", zero_cross_detect_en_o, 8'h01);
      chk("uv unarmed", undervoltage_event_o, 8'h00);
      ss_done_i = 1'b1;
      step(4);
      chk("zc held", zero_cross_detect_en_o, 8'h01);
      step(10);
      chk("zc off", zero_cross_detect_en_o, 8'h00);
      chk("uv wait", undervoltage_event_o, 8'h01);
      step(100);
      fb_below_uv_i = 1'b0;
      fb_above_pg_i = 1'b1;
      step(4);
      chk("uv clear", undervoltage_event_o, 8'h00);
      fb_above_pg_i = 1'b0;
      fb_below_uv_i = 1'b1;
      step(1740);
      chk("not yet", hiccup_active_o, 8'h00);
      step(13);
      chk("hiccup", hiccup_active_o, 8'h01);
      chk("stopped", converter_run_o, 8'h00);
      chk("no latch", latched_off_o, 8'h00);
      step(60);
      chk("asleep", hiccup_active_o, 8'h01);
      step(12);
      chk("restart", converter_run_o, 8'h01);
      conclude();
   end
endmodule
